//--- hw/obd_pkg.sv
// Package with the option byte decoder constants and types
package obd_pkg;
    // ****************************************************************
    // Load sequence
    // ****************************************************************
    localparam int LOAD_CYCLES = 43;
    localparam logic [5:0] LOAD_LAST = 6'h2a;
    localparam logic [5:0] OPT_ADDR_BYTE0 = 6'h00;
    localparam logic [5:0] OPT_ADDR_BYTE1 = 6'h01;
    localparam int FLASH_AW = 14;
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    // ****************************************************************
    // Option byte zero fields
    // ****************************************************************
    localparam int BIT_WDT_ACTION = 7;
    localparam int BIT_WDT_ALWAYS_ON = 6;
    localparam int OSC_HI = 5;
    localparam int OSC_LO = 4;
    localparam int BIT_BROWNOUT_ON = 3;
    localparam int BIT_READ_PROT = 2;
    localparam int BIT_WRITE_PROT = 0;

    typedef enum logic [1:0] {
        OSC_EXT_RC = 2'h0,
        OSC_LOW_POWER = 2'h1,
        OSC_MED_POWER = 2'h2,
        OSC_MAX_POWER = 2'h3
    } obd_osc_t;

    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam logic [3:0] REG_OPT0 = 4'h0;
    localparam logic [3:0] REG_OPT1 = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam logic [3:0] REG_IRQ_STAT = 4'hc;
    localparam logic [3:0] REG_IRQ_MASK = 4'h0;
    localparam logic [3:0] REG_IRQ_MASK_HI = 4'h1;
    localparam int IRQ_LOAD_DONE = 0;
    localparam int IRQ_WDT_INT = 1;
    localparam logic [1:0] IRQ_ZERO = 2'h0;
endpackage : obd_pkg

//--- hw/obd_flash_if.sv
// Interface carrying the flash read port of the option loader
`timescale 1ns/1ps
interface obd_flash_if;
    logic rd;
    logic info_sel;
    logic [obd_pkg::FLASH_AW-1:0] addr;
    logic [7:0] data;
    logic [5:0] index;
    logic capture;
    modport seq (output rd, output info_sel, output addr, output index, output capture,
        input data);
    modport top (input rd, input info_sel, input addr, input index, input capture,
        output data);
endinterface : obd_flash_if

//--- hw/obd_load_seq.sv
// Reset-time sequencer that walks the 43 option byte reads
`timescale 1ns/1ps
module obd_load_seq (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic NRST,
    // Flash side and done flag
    obd_flash_if.seq fl,
    output logic done
);
    typedef enum logic [2:0] {
        ST_LOAD = 3'h1,
        ST_DONE = 3'h2
    } obd_seq_t;

    obd_seq_t state_q, state_d;
    logic [5:0] cnt_q, cnt_d;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        unique case (state_q)
            ST_LOAD: begin
                if (cnt_q == obd_pkg::LOAD_LAST) begin
                    state_d = ST_DONE;
                end else begin
                    cnt_d = cnt_q + 6'h01;
                end
            end
            ST_DONE: begin
                cnt_d = cnt_q;
            end
            default: begin
                state_d = ST_LOAD;
                cnt_d = obd_pkg::OPT_ADDR_BYTE0;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            state_q <= ST_LOAD;
            cnt_q <= obd_pkg::OPT_ADDR_BYTE0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // First two bytes from program memory, rest from info area
    assign fl.rd = (state_q == ST_LOAD);
    assign fl.info_sel = (cnt_q > obd_pkg::OPT_ADDR_BYTE1);
    assign fl.addr = {{(obd_pkg::FLASH_AW-6){1'b0}}, cnt_q};
    assign fl.index = cnt_q;
    assign fl.capture = (state_q == ST_LOAD);
    assign done = (state_q == ST_DONE);
endmodule : obd_load_seq

//--- hw/obd_top.sv
// Option byte decoder: loads option bytes at reset and decodes them
// Operation
// - Option settings come from program memory bytes 0 and 1
// - Action bit 0 turns a watchdog time-out into an interrupt request
// - Action bit 1 makes a watchdog time-out a system reset; erased default
// - Bits 5:4 choose oscillator drive; 11 is the erased default
// - Reset spends 43 cycles reading flash via a six-bit counter
// - Bytes latch each clock; 0 and 1 program memory, rest info area
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ps
module obd_top (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic NRST,
    // Flash read port
    output logic FLASH_RD,
    output logic FLASH_INFO_SEL,
    output logic [obd_pkg::FLASH_AW-1:0] FLASH_ADDR,
    input wire logic [7:0] FLASH_DATA,
    // Watchdog side
    input wire logic WDT_TIMEOUT,
    output logic WDT_RESET_REQ,
    output logic WDT_IRQ_REQ,
    // Decoded options
    output logic LOAD_DONE,
    output logic WATCHDOG_ALWAYS_ON,
    output logic BROWNOUT_ALWAYS_ON,
    output logic FLASH_READ_PROTECT,
    output logic FLASH_WRITE_PROTECT,
    output logic [1:0] OSCILLATOR_DRIVE_SELECT,
    // Wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [3:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    output logic IRQ
);
    // ****************************************************************
    // Load sequence
    // ****************************************************************
    obd_flash_if fl ();
    logic seq_done;

    obd_load_seq u_seq (
        .SYS_CLK(SYS_CLK),
        .NRST(NRST),
        .fl(fl.seq),
        .done(seq_done)
    );
    assign fl.data = FLASH_DATA;

    // ****************************************************************
    // Option storage
    // ****************************************************************
    logic [7:0] opt0_q, opt0_d, opt1_q, opt1_d;
    logic done_q, done_d;
    logic rd_q, rd_d, info_q, info_d;
    logic [obd_pkg::FLASH_AW-1:0] addr_q, addr_d;
    // The flash answers the registered address, so the capture slot and index
    // travel one stage behind the counter; the data then matches the pins
    logic cap_q, cap_d;
    logic [5:0] idx_q, idx_d;
    logic prog_area;

    // Program memory supplies only the first two bytes
    assign prog_area = cap_q && !info_q;

    always_comb begin
        opt0_d = opt0_q;
        opt1_d = opt1_q;
        done_d = seq_done;
        rd_d = fl.rd;
        info_d = fl.info_sel;
        addr_d = fl.addr;
        cap_d = fl.capture;
        idx_d = fl.index;
        // Only bytes 0 and 1 hold user options
        // Capture only during the load, then hold
        if (prog_area && !done_q) begin
            if (idx_q == obd_pkg::OPT_ADDR_BYTE0) begin
                opt0_d = FLASH_DATA;
            end
            if (idx_q == obd_pkg::OPT_ADDR_BYTE1) begin
                opt1_d = FLASH_DATA;
            end
        end
    end

    // Latch fetched bytes on the rising clock
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            opt0_q <= obd_pkg::ERASED_BYTE;
            opt1_q <= obd_pkg::ERASED_BYTE;
            done_q <= 1'b0;
            rd_q <= 1'b0;
            info_q <= 1'b0;
            addr_q <= '0;
            cap_q <= 1'b0;
            idx_q <= obd_pkg::OPT_ADDR_BYTE0;
        end else begin
            opt0_q <= opt0_d;
            opt1_q <= opt1_d;
            done_q <= done_d;
            rd_q <= rd_d;
            info_q <= info_d;
            addr_q <= addr_d;
            cap_q <= cap_d;
            idx_q <= idx_d;
        end
    end

    // ****************************************************************
    // Decoded outputs and watchdog action
    // ****************************************************************
    logic wdt_rst_q, wdt_rst_d, wdt_irq_q, wdt_irq_d;
    logic action_reset;

    // Bit 7 set selects reset, erased byte gives reset
    assign action_reset = opt0_q[obd_pkg::BIT_WDT_ACTION];

    always_comb begin
        wdt_rst_d = 1'b0;
        wdt_irq_d = 1'b0;
        // Time-outs before the load ends are ignored: action not yet known
        if (WDT_TIMEOUT && done_q) begin
            wdt_rst_d = action_reset;
            // Time-out becomes an interrupt request when bit 7 is clear
            // WDT_IRQ_REQ is high one cycle late for as long as the time-out; bit 1 of the interrupt
            // status register holds it until software clears it
            wdt_irq_d = !action_reset;
        end
    end

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            wdt_rst_q <= 1'b0;
            wdt_irq_q <= 1'b0;
        end else begin
            wdt_rst_q <= wdt_rst_d;
            wdt_irq_q <= wdt_irq_d;
        end
    end

    assign WDT_RESET_REQ = wdt_rst_q;
    assign WDT_IRQ_REQ = wdt_irq_q;
    assign LOAD_DONE = done_q;
    assign FLASH_RD = rd_q;
    assign FLASH_INFO_SEL = info_q;
    assign FLASH_ADDR = addr_q;
    assign WATCHDOG_ALWAYS_ON = opt0_q[obd_pkg::BIT_WDT_ALWAYS_ON];
    assign BROWNOUT_ALWAYS_ON = opt0_q[obd_pkg::BIT_BROWNOUT_ON];
    assign FLASH_READ_PROTECT = opt0_q[obd_pkg::BIT_READ_PROT];
    assign FLASH_WRITE_PROTECT = opt0_q[obd_pkg::BIT_WRITE_PROT];
    // Oscillator drive field straight from bits 5:4
    assign OSCILLATOR_DRIVE_SELECT = opt0_q[obd_pkg::OSC_HI:obd_pkg::OSC_LO];

    // ****************************************************************
    // Wishbone registers and interrupt
    // ****************************************************************
    logic [1:0] ist_q, ist_d, imask_q, imask_d;
    logic ack_q, ack_d, irq_q, irq_d;
    logic [31:0] dat_q, dat_d;
    logic req, wr;
    logic [1:0] ev;

    // One-cycle answer; ack high blocks a second take of the same request
    assign req = WB_CYC_I && WB_STB_I && !ack_q;
    assign wr = req && WB_WE_I && WB_SEL_I[0];
    // Events are edges, so a held level sets its status bit only once
    assign ev = {wdt_irq_d && !wdt_irq_q, done_d && !done_q};

    always_comb begin
        ack_d = req;
        dat_d = dat_q;
        imask_d = imask_q;
        ist_d = ist_q;
        // Option bytes are read only: the settings must not move after load
        if (wr && WB_ADR_I == obd_pkg::REG_IRQ_STAT) begin
            ist_d = ist_q & ~WB_DAT_I[1:0];
        end
        if (wr && WB_ADR_I == obd_pkg::REG_STATUS) begin
            imask_d = WB_DAT_I[1:0];
        end
        // Set wins over a same-cycle clear
        ist_d = ist_d | ev;
        if (req) begin
            unique case (WB_ADR_I)
                obd_pkg::REG_OPT0: dat_d = {24'h000000, opt0_q};
                obd_pkg::REG_OPT1: dat_d = {24'h000000, opt1_q};
                obd_pkg::REG_STATUS: dat_d = {29'h00000000, done_q, imask_q};
                obd_pkg::REG_IRQ_STAT: dat_d = {30'h00000000, ist_q};
                default: dat_d = 32'h00000000;
            endcase
        end
        irq_d = |(ist_d & imask_d);
    end

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            ist_q <= obd_pkg::IRQ_ZERO;
            imask_q <= obd_pkg::IRQ_ZERO;
            ack_q <= 1'b0;
            dat_q <= 32'h00000000;
            irq_q <= 1'b0;
        end else begin
            ist_q <= ist_d;
            imask_q <= imask_d;
            ack_q <= ack_d;
            dat_q <= dat_d;
            irq_q <= irq_d;
        end
    end

    assign WB_ACK_O = ack_q;
    assign WB_DAT_O = dat_q;
    assign IRQ = irq_q;
endmodule : obd_top

//--- test/obd_asserts.sv
// Concurrent checks on the option byte decoder ports
`timescale 1ns/1ps
module obd_asserts (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic NRST,
    // Watched ports
    input wire logic FLASH_RD,
    input wire logic FLASH_INFO_SEL,
    input wire logic [obd_pkg::FLASH_AW-1:0] FLASH_ADDR,
    input wire logic WDT_TIMEOUT,
    input wire logic WDT_RESET_REQ,
    input wire logic WDT_IRQ_REQ,
    input wire logic LOAD_DONE,
    input wire logic [1:0] OSCILLATOR_DRIVE_SELECT
);
    logic [6:0] rd_cnt_q;
    logic [6:0] rd_cnt_d;
    always_comb begin
        rd_cnt_d = rd_cnt_q + {6'h00, FLASH_RD};
    end
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            rd_cnt_q <= 7'h00;
        end else begin
            rd_cnt_q <= rd_cnt_d;
        end
    end
    default clocking @(posedge SYS_CLK);
    endclocking
    default disable iff (!NRST);
    sequence load_end_s;
        FLASH_RD ##1 !FLASH_RD;
    endsequence
    load_count_a: assert property ($rose(LOAD_DONE) |-> rd_cnt_q == 7'h2b)
        else $error("load read count wrong");
    load_finish_a: assert property (load_end_s |-> ##[0:2] LOAD_DONE)
        else $error("load done late");
    addr_upper_a: assert property (FLASH_RD |-> FLASH_ADDR[13:6] == 8'h00)
        else $error("upper address bits set");
    area_select_a: assert property (FLASH_RD |-> FLASH_INFO_SEL == (FLASH_ADDR > 14'h0001))
        else $error("flash area select wrong");
    reads_stop_a: assert property (LOAD_DONE |-> !FLASH_RD)
        else $error("flash read after load");
    settings_hold_a: assert property (LOAD_DONE |=> LOAD_DONE && $stable(OSCILLATOR_DRIVE_SELECT))
        else $error("settings changed after load");
    wdt_request_a: assert property (LOAD_DONE && WDT_TIMEOUT |=> WDT_RESET_REQ ^ WDT_IRQ_REQ)
        else $error("timeout gave no single request");
    wdt_quiet_a: assert property (!WDT_TIMEOUT |=> !(WDT_RESET_REQ || WDT_IRQ_REQ))
        else $error("request without timeout");
endmodule : obd_asserts
bind obd_top obd_asserts i_asserts (.SYS_CLK(SYS_CLK), .NRST(NRST), .FLASH_RD(FLASH_RD),
    .FLASH_INFO_SEL(FLASH_INFO_SEL), .FLASH_ADDR(FLASH_ADDR), .WDT_TIMEOUT(WDT_TIMEOUT),
    .WDT_RESET_REQ(WDT_RESET_REQ), .WDT_IRQ_REQ(WDT_IRQ_REQ), .LOAD_DONE(LOAD_DONE),
    .OSCILLATOR_DRIVE_SELECT(OSCILLATOR_DRIVE_SELECT));

//--- test/obd_flash_model.sv
// Flash array model answering the reset-time option reads
`timescale 1ns/1ps
module obd_flash_model (
    // Read request from the loader
    input wire logic FLASH_RD,
    input wire logic FLASH_INFO_SEL,
    input wire logic [obd_pkg::FLASH_AW-1:0] FLASH_ADDR,
    // Stored option bytes
    input wire logic [7:0] byte0,
    input wire logic [7:0] byte1,
    // Read data
    output logic [7:0] FLASH_DATA
);
    logic [7:0] word;
    // Answers the address on the pins; info bytes never equal a stored option
    // byte, so a capture from the wrong area or address shows
    always_comb begin
        word = 8'h3c;
        if (FLASH_INFO_SEL) begin
            word = FLASH_ADDR[7:0] ^ 8'ha5;
        end else if (FLASH_ADDR == 14'h0000) begin
            word = byte0;
        end else if (FLASH_ADDR == 14'h0001) begin
            word = byte1;
        end
        // Outside a read the array output is not valid: show the inverse
        FLASH_DATA = FLASH_RD ? word : ~word;
    end
endmodule : obd_flash_model

//--- test/option_byte_decoder_tb.sv
// Self-checking bench of the option byte decoder
`timescale 1ns/1ps
module option_byte_decoder_tb;
    logic SYS_CLK = 1'b0;
    logic NRST = 1'b0;
    logic WDT_TIMEOUT = 1'b0;
    logic WB_CYC_I = 1'b0;
    logic WB_STB_I = 1'b0;
    logic WB_WE_I = 1'b0;
    logic [3:0] WB_ADR_I = 4'h0;
    logic [3:0] WB_SEL_I = 4'h0;
    logic frd, finfo;
    logic [obd_pkg::FLASH_AW-1:0] faddr;
    logic [31:0] WB_DAT_I = 32'h0;
    logic [7:0] byte0 = 8'hff;
    logic [7:0] byte1 = 8'hff;
    logic [7:0] FLASH_DATA;
    logic [31:0] WB_DAT_O;
    logic [31:0] rd;
    logic [1:0] osc;
    logic WB_ACK_O, IRQ, wdr, wdi, LOAD_DONE, wao, bao, flash_read_protect, flash_write_protect;
    int mismatches = 0;
    int n_checks = 0;
    int cycles = 0;
    obd_top i_dut (.SYS_CLK(SYS_CLK), .NRST(NRST), .FLASH_RD(frd), .FLASH_INFO_SEL(finfo),
        .FLASH_ADDR(faddr), .FLASH_DATA(FLASH_DATA), .WDT_TIMEOUT(WDT_TIMEOUT),
        .WDT_RESET_REQ(wdr), .WDT_IRQ_REQ(wdi), .LOAD_DONE(LOAD_DONE),
        .WATCHDOG_ALWAYS_ON(wao), .BROWNOUT_ALWAYS_ON(bao), .FLASH_READ_PROTECT(flash_read_protect),
        .FLASH_WRITE_PROTECT(flash_write_protect), .OSCILLATOR_DRIVE_SELECT(osc), .WB_CYC_I(WB_CYC_I),
        .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
        .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .IRQ(IRQ));
    obd_flash_model i_flash (.FLASH_RD(frd), .FLASH_INFO_SEL(finfo), .FLASH_ADDR(faddr),
        .byte0(byte0), .byte1(byte1), .FLASH_DATA(FLASH_DATA));
    initial begin
        forever #5 SYS_CLK = ~SYS_CLK;
    end
    always @(posedge SYS_CLK) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            mismatches++;
            wrap_up();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up
    // Classic single cycle; the answer is taken at the edge that sees ack
    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
        @(posedge SYS_CLK);
        WB_CYC_I <= 1'b1;
        WB_STB_I <= 1'b1;
        WB_WE_I <= we;
        WB_ADR_I <= adr;
        WB_SEL_I <= 4'hf;
        WB_DAT_I <= dat;
        // Only the bench timeout ends a wait for ack
        do begin
            @(posedge SYS_CLK);
        end while (WB_ACK_O !== 1'b1);
        rd = WB_DAT_O;
        WB_CYC_I <= 1'b0;
        WB_STB_I <= 1'b0;
        WB_SEL_I <= 4'h0;
    endtask : wb
    task automatic load(input logic [7:0] b0, input int hold);
        @(posedge SYS_CLK);
        NRST <= 1'b0;
        byte0 <= b0;
        byte1 <= ~b0;
        repeat (hold) @(posedge SYS_CLK);
        NRST <= 1'b1;
        while (LOAD_DONE !== 1'b1) begin
            @(posedge SYS_CLK);
        end
        #1;
        check(osc, b0[5:4]);
        check({wao, bao, flash_read_protect, flash_write_protect}, {b0[6], b0[3:2], b0[0]});
        wb(1'b1, 4'h0, 32'hffffffff);
        wb(1'b0, 4'h0, 32'h0);
        check(rd, {24'h0, b0});
        wb(1'b0, 4'h4, 32'h0);
        check(rd, {24'h0, ~b0});
        @(posedge SYS_CLK);
        WDT_TIMEOUT <= 1'b1;
        @(posedge SYS_CLK);
        WDT_TIMEOUT <= 1'b0;
        #1;
        check({wdr, wdi}, {b0[7], ~b0[7]});
    endtask : load
    task automatic irq_test();
        wb(1'b0, 4'hc, 32'h0);
        check(rd, 32'h3);
        // processor enables the watchdog request first
        wb(1'b1, 4'h8, 32'h2);
        repeat (2) @(posedge SYS_CLK);
        check(IRQ, 1'b1);
        wb(1'b1, 4'hc, 32'h2);
        repeat (2) @(posedge SYS_CLK);
        check(IRQ, 1'b0);
        wb(1'b0, 4'hc, 32'h0);
        check(rd, 32'h1);
        wb(1'b0, 4'h8, 32'h0);
        check(rd, 32'h6);
        wb(1'b0, 4'h2, 32'h0);
        check(rd, 32'h0);
    endtask : irq_test
    initial begin
        load(8'h0a, 15);
        load(8'h95, 2);
        load(8'hff, 2);
        load(8'h26, 2);
        irq_test();
        wrap_up();
    end
endmodule : option_byte_decoder_tb
